// ---- rtl/trq_cmd_filter.sv ----
// torque command selection, scaling, smoothing and resonance suppression settings
`timescale 1ns/1ps

module trq_cmd_filter #(
	parameter int TICK_CYCLES = trq_pkg::LOOP_CYCLES,
	parameter bit ABOVE_1KW = 1'b0
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [trq_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// select pins, asynchronous
	input wire logic torque_select_bit0,
	input wire logic torque_select_bit1,
	// samples from logic on pclk
	input wire logic signed [15:0] analog_in_mv,
	input wire logic signed [15:0] speed_loop_in,
	// results
	output logic signed [15:0] torque_cmd_pct,
	output logic torque_is_limit,
	output logic cmd_update,
	output logic signed [15:0] speed_loop_out,
	output logic notch_active,
	output logic [15:0] notch_freq_hz,
	output logic [5:0] notch_depth_db
);
	import trq_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] clamp_u(input logic [31:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		logic [15:0] r;
		r = v[15:0];
		if (v > {16'h0000, hi}) begin
			r = hi;
		end else if (v < {16'h0000, lo}) begin
			r = lo;
		end
		return r;
	endfunction

	function automatic logic [15:0] clamp_preset(input logic [31:0] v);
		logic signed [31:0] s;
		logic [15:0] r;
		s = signed'(v);
		r = v[15:0];
		if (s > 32'(PRESET_MAX)) begin
			r = PRESET_MAX;
		end else if (s < -32'(PRESET_MAX)) begin
			r = 16'(-PRESET_MAX);
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic [11:0] idx;
	logic acc_phase;
	logic wr_en;
	logic hit;
	logic [31:0] rd_mux;

	logic [15:0] smooth_time_r;
	logic [15:0] full_scale_r;
	logic [15:0] notch_freq_r;
	logic [15:0] notch_depth_r;
	logic [15:0] reson_time_r;
	logic [15:0] preset_r [3];
	logic [1:0] mode_r;
	logic [1:0] sel_code_r;
	logic [31:0] status_w;

	assign idx = paddr[ADDR_W-1:2];
	assign acc_phase = psel && penable;
	assign wr_en = acc_phase && pready && pwrite && hit;
	// current-loop gains have no address at all, so they decode as unmapped
	assign hit = (idx == IDX_SMOOTH) || (idx == IDX_FULL_SCALE) || (idx == IDX_NOTCH_FREQ)
		|| (idx == IDX_NOTCH_DEPTH) || (idx == IDX_RESON) || (idx == IDX_PRESET_ONE)
		|| (idx == IDX_PRESET_TWO) || (idx == IDX_PRESET_THREE) || (idx == IDX_MODE)
		|| (idx == IDX_STATUS && !pwrite);
	assign status_w = {10'h000, torque_is_limit, notch_active, mode_r, sel_code_r,
		torque_cmd_pct};
	assign rd_mux = (idx == IDX_SMOOTH) ? {16'h0000, smooth_time_r} :
		(idx == IDX_FULL_SCALE) ? {16'h0000, full_scale_r} :
		(idx == IDX_NOTCH_FREQ) ? {16'h0000, notch_freq_r} :
		(idx == IDX_NOTCH_DEPTH) ? {16'h0000, notch_depth_r} :
		(idx == IDX_RESON) ? {16'h0000, reson_time_r} :
		(idx == IDX_PRESET_ONE) ? {{16{preset_r[0][15]}}, preset_r[0]} :
		(idx == IDX_PRESET_TWO) ? {{16{preset_r[1][15]}}, preset_r[1]} :
		(idx == IDX_PRESET_THREE) ? {{16{preset_r[2][15]}}, preset_r[2]} :
		(idx == IDX_MODE) ? {30'h00000000, mode_r} :
		(idx == IDX_STATUS) ? status_w : 32'h00000000;

	// one wait state: pready rises in the second access cycle, so outputs stay registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= acc_phase && !pready;
			pslverr <= acc_phase && !pready && !hit;
			prdata <= (acc_phase && !pready && !pwrite) ? rd_mux : 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// settings registers, clamped as written
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			smooth_time_r <= RST_SMOOTH;
			full_scale_r <= RST_FULL_SCALE;
			notch_freq_r <= RST_NOTCH_FREQ;
			notch_depth_r <= RST_NOTCH_DEPTH; // zero: notch off
			reson_time_r <= ABOVE_1KW ? RST_RESON_LARGE : RST_RESON_SMALL;
			preset_r[0] <= RST_PRESET;
			preset_r[1] <= RST_PRESET;
			preset_r[2] <= RST_PRESET;
			mode_r <= MODE_POSITION;
		end else if (wr_en) begin
			unique case (idx)
				IDX_SMOOTH: smooth_time_r <= clamp_u(pwdata, 16'h0000, TIME_MAX);
				IDX_FULL_SCALE: full_scale_r <= clamp_u(pwdata, 16'h0000, FULL_SCALE_MAX);
				IDX_NOTCH_FREQ: notch_freq_r <= clamp_u(pwdata, NOTCH_FREQ_MIN, NOTCH_FREQ_MAX);
				IDX_NOTCH_DEPTH: notch_depth_r <= clamp_u(pwdata, 16'h0000, NOTCH_DEPTH_MAX);
				IDX_RESON: reson_time_r <= clamp_u(pwdata, 16'h0000, TIME_MAX);
				IDX_PRESET_ONE: preset_r[0] <= clamp_preset(pwdata);
				IDX_PRESET_TWO: preset_r[1] <= clamp_preset(pwdata);
				IDX_PRESET_THREE: preset_r[2] <= clamp_preset(pwdata);
				IDX_MODE: mode_r <= pwdata[1:0];
				default: mode_r <= mode_r;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// select pins: three flops, a change counts once stages two and three agree
	// ----------------------------------------------------------------
	logic [2:0] sel0_q;
	logic [2:0] sel1_q;

	// on reads as 1, off as 0; the code only moves when a pin settles to a new level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel0_q <= 3'b000;
			sel1_q <= 3'b000;
			sel_code_r <= 2'b00;
		end else begin
			sel0_q <= {sel0_q[1:0], torque_select_bit0};
			sel1_q <= {sel1_q[1:0], torque_select_bit1};
			if (sel0_q[1] == sel0_q[2]) begin
				sel_code_r[0] <= sel0_q[2];
			end
			if (sel1_q[1] == sel1_q[2]) begin
				sel_code_r[1] <= sel1_q[2];
			end
		end
	end

	// ----------------------------------------------------------------
	// loop tick and settings snapshot
	// ----------------------------------------------------------------
	logic [31:0] tick_cnt_r;
	logic tick;
	logic [15:0] act_smooth_r;
	logic [15:0] act_full_r;
	logic [15:0] act_reson_r;
	logic [15:0] act_preset_r [3];
	logic [1:0] act_mode_r;
	logic [1:0] act_sel_r;
	logic signed [15:0] x_mv_r;
	logic signed [15:0] spd_r;

	assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

	// settings other than notch frequency and depth are sampled only at the tick, so their writes never land mid-update
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_r <= 32'h00000000;
			act_smooth_r <= RST_SMOOTH;
			act_full_r <= RST_FULL_SCALE;
			act_reson_r <= ABOVE_1KW ? RST_RESON_LARGE : RST_RESON_SMALL;
			act_preset_r[0] <= RST_PRESET;
			act_preset_r[1] <= RST_PRESET;
			act_preset_r[2] <= RST_PRESET;
			act_mode_r <= MODE_POSITION;
			act_sel_r <= 2'b00;
			x_mv_r <= 16'sh0000;
			spd_r <= 16'sh0000;
		end else begin
			tick_cnt_r <= tick ? 32'h00000000 : tick_cnt_r + 32'h00000001;
			if (tick) begin
				act_smooth_r <= smooth_time_r;
				act_full_r <= full_scale_r;
				act_reson_r <= reson_time_r;
				act_preset_r <= preset_r;
				act_mode_r <= mode_r;
				act_sel_r <= sel_code_r;
				// the input span is +/-10 V; anything beyond is held at the rail
				x_mv_r <= (analog_in_mv > ANALOG_MAX_MV) ? ANALOG_MAX_MV :
					(analog_in_mv < -ANALOG_MAX_MV) ? -ANALOG_MAX_MV : analog_in_mv;
				spd_r <= speed_loop_in;
			end
		end
	end

	// ----------------------------------------------------------------
	// shared serial divider, one quotient bit per cycle
	// ----------------------------------------------------------------
	logic div_start;
	logic [31:0] div_a;
	logic [15:0] div_b;
	logic [31:0] div_q_r;
	logic [16:0] div_rem_r;
	logic [15:0] div_b_r;
	logic [5:0] div_cnt_r;
	logic div_busy;
	logic [16:0] rem_sh;

	assign div_busy = (div_cnt_r != 6'h00);
	assign rem_sh = {div_rem_r[15:0], div_q_r[31]};

	// one divider shared by all three stages; the loop period leaves ample time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q_r <= 32'h00000000;
			div_rem_r <= 17'h00000;
			div_b_r <= 16'h0001;
			div_cnt_r <= 6'h00;
		end else if (div_start) begin
			div_q_r <= div_a;
			div_rem_r <= 17'h00000;
			div_b_r <= div_b;
			div_cnt_r <= 6'(DIV_STEPS);
		end else if (div_busy) begin
			div_rem_r <= (rem_sh >= {1'b0, div_b_r}) ? rem_sh - {1'b0, div_b_r} : rem_sh;
			div_q_r <= {div_q_r[30:0], rem_sh >= {1'b0, div_b_r}};
			div_cnt_r <= div_cnt_r - 6'h01;
		end
	end

	// ----------------------------------------------------------------
	// update sequence: scale, smooth, resonance low-pass, publish
	// ----------------------------------------------------------------
	trq_seq_e seq_r;
	trq_seq_e seq_nxt;
	logic signed [15:0] analog_pct_r;
	logic signed [15:0] smooth_y_r;
	logic signed [15:0] reson_y_r;
	logic signed [16:0] src_pct;
	logic signed [16:0] sm_diff;
	logic signed [16:0] rs_diff;
	logic [16:0] sm_abs;
	logic [16:0] rs_abs;
	logic [31:0] scale_prod;
	logic signed [15:0] q16;
	logic signed [15:0] ana_pct;

	assign scale_prod = 32'(x_mv_r[15] ? -x_mv_r : x_mv_r) * 32'(act_full_r);
	// select 00 takes analog or zero by mode, else one of the presets
	assign src_pct = (act_sel_r == 2'b00) ?
		((act_mode_r == MODE_TORQUE_ZERO) ? 17'sh00000 : 17'(ana_pct)) :
		17'(signed'(act_preset_r[act_sel_r - 2'b01]));
	assign sm_diff = src_pct - 17'(smooth_y_r);
	assign rs_diff = 17'(spd_r) - 17'(reson_y_r);
	assign sm_abs = sm_diff[16] ? 17'(-sm_diff) : 17'(sm_diff);
	assign rs_abs = rs_diff[16] ? 17'(-rs_diff) : 17'(rs_diff);
	assign q16 = signed'(div_q_r[15:0]);
	// in SEQ_SM_GO the scale quotient comes straight off the divider, else the analog
	// path would publish the previous update's value; later stages use the registered copy
	assign ana_pct = (seq_r == SEQ_SM_GO) ? (x_mv_r[15] ? -q16 : q16) : analog_pct_r;

	// next state and divider requests
	always_comb begin
		seq_nxt = seq_r;
		div_start = 1'b0;
		div_a = 32'h00000000;
		div_b = 16'h0001;
		unique case (seq_r)
			SEQ_IDLE: begin
				if (tick) begin
					seq_nxt = SEQ_SCALE;
				end
			end
			SEQ_SCALE: begin
				// 10 V (10000 mV) gives the full-scale percentage
				div_start = !div_busy;
				div_a = scale_prod;
				div_b = SCALE_DIVISOR;
				seq_nxt = SEQ_SM_GO;
			end
			SEQ_SM_GO: begin
				if (!div_busy) begin
					div_start = (act_smooth_r != 16'h0000) && (act_sel_r == 2'b00);
					div_a = 32'(sm_abs);
					div_b = act_smooth_r;
					seq_nxt = div_start ? SEQ_SM_WAIT : SEQ_RS_GO;
				end
			end
			SEQ_SM_WAIT: begin
				if (!div_busy) begin
					seq_nxt = SEQ_RS_GO;
				end
			end
			SEQ_RS_GO: begin
				div_start = (act_reson_r != 16'h0000);
				div_a = 32'(rs_abs);
				div_b = act_reson_r;
				seq_nxt = div_start ? SEQ_RS_WAIT : SEQ_OUT;
			end
			SEQ_RS_WAIT: begin
				if (!div_busy) begin
					seq_nxt = SEQ_OUT;
				end
			end
			SEQ_OUT: seq_nxt = SEQ_IDLE;
			default: seq_nxt = SEQ_IDLE;
		endcase
	end

	// filter state: y += (x - y) / tau once per millisecond
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_r <= SEQ_IDLE;
			analog_pct_r <= 16'sh0000;
			smooth_y_r <= 16'sh0000;
			reson_y_r <= 16'sh0000;
		end else begin
			seq_r <= seq_nxt;
			if (seq_r == SEQ_SM_GO && !div_busy) begin
				analog_pct_r <= x_mv_r[15] ? -q16 : q16;
			end
			if (seq_r == SEQ_SM_GO && !div_busy && !div_start) begin
				smooth_y_r <= src_pct[15:0]; // zero time or preset: pass through
			end else if (seq_r == SEQ_SM_WAIT && !div_busy) begin
				smooth_y_r <= sm_diff[16] ? smooth_y_r - q16 : smooth_y_r + q16;
			end
			if (seq_r == SEQ_RS_GO && !div_start) begin
				reson_y_r <= spd_r; // zero time bypasses
			end else if (seq_r == SEQ_RS_WAIT && !div_busy) begin
				// a longer time constant takes a smaller step: lower bandwidth
				reson_y_r <= rs_diff[16] ? reson_y_r - q16 : reson_y_r + q16;
			end
		end
	end

	// ----------------------------------------------------------------
	// published results
	// ----------------------------------------------------------------
	// all outputs change together in SEQ_OUT so a reader never sees a mixed set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			torque_cmd_pct <= 16'sh0000;
			torque_is_limit <= 1'b1;
			cmd_update <= 1'b0;
			speed_loop_out <= 16'sh0000;
			notch_active <= 1'b0;
			notch_freq_hz <= 16'h0000;
			notch_depth_db <= 6'h00;
		end else begin
			cmd_update <= (seq_r == SEQ_OUT);
			if (seq_r == SEQ_OUT) begin
				torque_cmd_pct <= smooth_y_r;
				torque_is_limit <= (act_mode_r == MODE_POSITION)
					|| (act_mode_r == MODE_SPEED);
				speed_loop_out <= reson_y_r;
				notch_active <= (notch_depth_r != 16'h0000);
				notch_freq_hz <= (notch_depth_r != 16'h0000) ? notch_freq_r : 16'h0000;
				notch_depth_db <= notch_depth_r[5:0];
			end
		end
	end
endmodule

// ---- rtl/trq_pkg.sv ----
// constants, register map and types of the torque command and resonance filter block
package trq_pkg;
	// ----------------------------------------------------------------
	// register indices (byte address = 4 * index)
	// ----------------------------------------------------------------
	localparam logic [11:0] IDX_SMOOTH = 12'h107;
	localparam logic [11:0] IDX_FULL_SCALE = 12'h129;
	localparam logic [11:0] IDX_NOTCH_FREQ = 12'h217;
	localparam logic [11:0] IDX_NOTCH_DEPTH = 12'h218;
	localparam logic [11:0] IDX_RESON = 12'h219;
	localparam logic [11:0] IDX_PRESET_ONE = 12'h300;
	localparam logic [11:0] IDX_PRESET_TWO = 12'h301;
	localparam logic [11:0] IDX_PRESET_THREE = 12'h302;
	localparam logic [11:0] IDX_MODE = 12'h303;
	localparam logic [11:0] IDX_STATUS = 12'h304;
	localparam int ADDR_W = 14;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_SMOOTH = 16'h0000;
	localparam logic [15:0] RST_FULL_SCALE = 16'h0064;
	localparam logic [15:0] RST_NOTCH_FREQ = 16'h03E8;
	localparam logic [15:0] RST_NOTCH_DEPTH = 16'h0000;
	localparam logic [15:0] RST_RESON_SMALL = 16'h0002;
	localparam logic [15:0] RST_RESON_LARGE = 16'h0005;
	localparam logic [15:0] RST_PRESET = 16'h0000;

	// ----------------------------------------------------------------
	// setting ranges
	// ----------------------------------------------------------------
	localparam logic [15:0] TIME_MAX = 16'h03E8;
	localparam logic [15:0] FULL_SCALE_MAX = 16'h03E8;
	localparam logic [15:0] NOTCH_FREQ_MIN = 16'h0032;
	localparam logic [15:0] NOTCH_FREQ_MAX = 16'h03E8;
	localparam logic [15:0] NOTCH_DEPTH_MAX = 16'h0020;
	localparam logic signed [15:0] PRESET_MAX = 16'sh012C;
	localparam logic signed [15:0] ANALOG_MAX_MV = 16'sh2710;
	localparam logic [15:0] SCALE_DIVISOR = 16'h2710;

	// ----------------------------------------------------------------
	// status fields
	// ----------------------------------------------------------------
	localparam int ST_CMD_LSB = 0;
	localparam int ST_SEL_LSB = 16;
	localparam int ST_MODE_LSB = 18;
	localparam int ST_NOTCH_BIT = 20;
	localparam int ST_LIMIT_BIT = 21;

	// ----------------------------------------------------------------
	// timing: one control-loop update per millisecond
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_HZ = 40000000;
	localparam int LOOP_PERIOD_US = 1000;
	localparam int LOOP_CYCLES = (CLK_FREQ_HZ / 1000000) * LOOP_PERIOD_US;
	localparam int DIV_STEPS = 32;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_POSITION = 2'b00,
		MODE_SPEED = 2'b01,
		MODE_TORQUE = 2'b10,
		MODE_TORQUE_ZERO = 2'b11
	} trq_mode_e;

	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b000,
		SEQ_SCALE = 3'b001,
		SEQ_SM_GO = 3'b010,
		SEQ_SM_WAIT = 3'b011,
		SEQ_RS_GO = 3'b100,
		SEQ_RS_WAIT = 3'b101,
		SEQ_OUT = 3'b110
	} trq_seq_e;
endpackage

// ---- test/trq_cmd_filter_props.sv ----
// concurrent checks on the ports of the torque command and resonance filter block
`timescale 1ns/1ps
module trq_cmd_filter_chk
	import trq_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// results
	input wire logic signed [15:0] torque_cmd_pct,
	input wire logic torque_is_limit,
	input wire logic cmd_update,
	input wire logic signed [15:0] speed_loop_out,
	input wire logic notch_active,
	input wire logic [15:0] notch_freq_hz,
	input wire logic [5:0] notch_depth_db
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------------------------------
	// notch settings
	// ----------------------------------------------------------------
	a_notch_freq_span: assert property (notch_active |->
		notch_freq_hz >= NOTCH_FREQ_MIN && notch_freq_hz <= NOTCH_FREQ_MAX)
		else $error("notch frequency outside its span");
	a_notch_off_silent: assert property (!notch_active |-> notch_freq_hz == 16'h0000)
		else $error("notch frequency shown while notch is off");
	a_notch_by_depth: assert property (notch_active == (notch_depth_db != 6'h00))
		else $error("notch enable does not follow depth");
	a_depth_span: assert property (notch_depth_db <= 6'h20)
		else $error("notch depth above its span");
	// ----------------------------------------------------------------
	// loop outputs move only with the update pulse
	// ----------------------------------------------------------------
	a_update_pulse: assert property (cmd_update |=> !cmd_update)
		else $error("update pulse longer than one cycle");
	a_cmd_held: assert property ($changed(torque_cmd_pct) ||
		$changed(torque_is_limit) |-> cmd_update)
		else $error("command moved without an update");
	a_speed_held: assert property ($changed(speed_loop_out) |-> cmd_update)
		else $error("speed output moved without an update");
	a_cmd_span: assert property (torque_cmd_pct >= -16'sd1000 && torque_cmd_pct <= 16'sd1000)
		else $error("command beyond full-scale reach");
	// ----------------------------------------------------------------
	// register access timing
	// ----------------------------------------------------------------
	a_one_wait_state: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("apb answer not after one wait state");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready held too long");
	cover property (cmd_update && !torque_is_limit);
	cover property (cmd_update && torque_is_limit);
	cover property (notch_active);
endmodule

bind trq_cmd_filter trq_cmd_filter_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .torque_cmd_pct(torque_cmd_pct),
	.torque_is_limit(torque_is_limit), .cmd_update(cmd_update), .speed_loop_out(speed_loop_out),
	.notch_active(notch_active), .notch_freq_hz(notch_freq_hz), .notch_depth_db(notch_depth_db));

// ---- test/trq_cmd_filter_tb.sv ----
// self-checking bench of the torque command and resonance filter block
`timescale 1ns/1ps
module trq_cmd_filter_tb;
	import trq_pkg::*;
	`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
		$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
	typedef struct packed {
		logic signed [15:0] cmd;
		logic lim;
		logic signed [15:0] spd;
		logic act;
		logic [15:0] frq;
		logic [5:0] dep;
	} trq_note_s;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready, pslverr, b0, b1, torque_is_limit, cmd_update, notch_active;
	logic signed [15:0] mv, spd_in, torque_cmd_pct, speed_loop_out;
	logic [15:0] notch_freq_hz;
	logic [5:0] notch_depth_db;
	logic [1:0] sel_req = 2'b00;
	logic signed [15:0] mv_req = 16'sh0000;
	logic signed [15:0] spd_req = 16'sh0000;
	logic [32:0] rdq[$];
	trq_note_s cq[$];
	int mismatches = 0;
	int checks = 0;
	logic act = 1'b0;
	logic [15:0] frq = 16'h0000;
	logic [5:0] dep = 6'h00;

	always #12.5 pclk = ~pclk;

	// short tick keeps the run brief; the waits below are fixed cycle counts, not derived from it
	trq_cmd_filter #(.TICK_CYCLES(200), .ABOVE_1KW(1'b0)) dut (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .torque_select_bit0(b0),
		.torque_select_bit1(b1), .analog_in_mv(mv), .speed_loop_in(spd_in),
		.torque_cmd_pct(torque_cmd_pct), .torque_is_limit(torque_is_limit),
		.cmd_update(cmd_update), .speed_loop_out(speed_loop_out), .notch_active(notch_active),
		.notch_freq_hz(notch_freq_hz), .notch_depth_db(notch_depth_db));
	trq_far_side far (.pclk(pclk), .presetn(presetn), .sel_req(sel_req), .mv_req(mv_req),
		.spd_req(spd_req), .torque_select_bit0(b0), .torque_select_bit1(b1),
		.analog_in_mv(mv), .speed_loop_in(spd_in));

	// ----------------------------------------------------------------
	// monitors: oldest note against each answer
	// ----------------------------------------------------------------
	always @(posedge pclk) begin
		if (presetn && pready === 1'b1 && rdq.size() > 0) begin
			`CHK({pslverr, prdata}, rdq.pop_front())
		end
		if (presetn && cmd_update === 1'b1 && cq.size() > 0) begin
			`CHK({torque_cmd_pct, torque_is_limit, speed_loop_out, notch_active, notch_freq_hz,
				notch_depth_db}, cq.pop_front())
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
		input logic [31:0] exp, input logic err);
		int n;
		n = 0;
		@(posedge pclk);
		rdq.push_back({err, exp});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wupd();
		int k;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (cmd_update !== 1'b1 && k < 1000);
		@(posedge pclk);
	endtask

	// the first update may hold an old snapshot, so the note waits for the next one
	task automatic expc(input logic signed [15:0] c, input logic l, input logic signed [15:0] s);
		wupd();
		cq.push_back('{c, l, s, act, act ? frq : 16'h0000, dep});
		wupd();
	endtask

	function automatic logic signed [15:0] ana(input int v, input int fs);
		int a;
		a = (v < 0 ? -v : v) * fs / 10000;
		return 16'(v < 0 ? -a : a);
	endfunction

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (80000) @(posedge pclk);
		mismatches++;
		$display("[ERR] %0t watchdog expired", $time);
		tally_and_finish();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int fs, v, s, x, y, r;
		void'($urandom(8));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, IDX_SMOOTH, 0, 32'h0, 0);
		apb(0, IDX_FULL_SCALE, 0, 32'h64, 0);
		apb(0, IDX_NOTCH_FREQ, 0, 32'h3E8, 0);
		apb(0, IDX_NOTCH_DEPTH, 0, 32'h0, 0);
		apb(0, IDX_RESON, 0, 32'h2, 0);
		apb(0, 12'h000, 0, 32'h0, 1);
		apb(1, IDX_STATUS, 32'h1, 32'h0, 1);
		// writes beyond the span come back clamped
		apb(1, IDX_NOTCH_FREQ, 32'hA, 32'h0, 0);
		apb(0, IDX_NOTCH_FREQ, 0, 32'h32, 0);
		apb(1, IDX_NOTCH_FREQ, 32'h7D0, 32'h0, 0);
		apb(0, IDX_NOTCH_FREQ, 0, 32'h3E8, 0);
		apb(1, IDX_NOTCH_DEPTH, 32'h28, 32'h0, 0);
		apb(0, IDX_NOTCH_DEPTH, 0, 32'h20, 0);
		apb(1, IDX_FULL_SCALE, 32'h1388, 32'h0, 0);
		apb(0, IDX_FULL_SCALE, 0, 32'h3E8, 0);
		apb(1, IDX_FULL_SCALE, 32'h64, 32'h0, 0);
		apb(1, IDX_SMOOTH, 32'hBB8, 32'h0, 0);
		apb(0, IDX_SMOOTH, 0, 32'h3E8, 0);
		apb(1, IDX_SMOOTH, 32'h0, 32'h0, 0);
		apb(1, IDX_RESON, 32'h0, 32'h0, 0);
		apb(0, IDX_RESON, 0, 32'h0, 0);
		act = 1'b1;
		frq = 16'h03E8;
		dep = 6'h20;
		// every mode with both contacts open
		mv_req <= 16'sd6000;
		spd_req <= 16'sd1234;
		for (int m = 0; m < 4; m++) begin
			apb(1, IDX_MODE, 32'(m), 32'h0, 0);
			expc(m == 3 ? 16'sd0 : ana(6000, 100), m < 2, 16'sd1234);
		end
		// presets, the second clamped to -300
		apb(1, IDX_PRESET_ONE, 32'h96, 32'h0, 0);
		apb(1, IDX_PRESET_TWO, 32'hFFFFFE70, 32'h0, 0);
		apb(0, IDX_PRESET_TWO, 0, 32'hFFFFFED4, 0);
		apb(1, IDX_PRESET_THREE, 32'h12C, 32'h0, 0);
		apb(1, IDX_MODE, 32'h2, 32'h0, 0);
		sel_req <= 2'b01;
		expc(16'sd150, 1'b0, 16'sd1234);
		sel_req <= 2'b10;
		expc(-16'sd300, 1'b0, 16'sd1234);
		sel_req <= 2'b11;
		apb(1, IDX_MODE, 32'h1, 32'h0, 0);
		expc(16'sd300, 1'b1, 16'sd1234);
		// random analog levels and full-scale settings in torque mode
		apb(1, IDX_MODE, 32'h2, 32'h0, 0);
		sel_req <= 2'b00;
		for (int i = 0; i < 6; i++) begin
			fs = $urandom_range(1000, 0);
			v = int'($urandom_range(20000, 0)) - 10000;
			s = int'($urandom_range(20000, 0)) - 10000;
			apb(1, IDX_FULL_SCALE, 32'(fs), 32'h0, 0);
			mv_req <= 16'(v);
			spd_req <= 16'(s);
			expc(ana(v, fs), 1'b0, 16'(s));
		end
		// zero depth switches the notch off whatever the frequency
		apb(1, IDX_NOTCH_DEPTH, 32'h0, 32'h0, 0);
		act = 1'b0;
		dep = 6'h00;
		expc(ana(v, fs), 1'b0, 16'(s));
		// status word mirrors limit flag, notch, mode, selection and command
		apb(0, IDX_STATUS, 0, {10'h000, 1'b0, 1'b0, 2'b10, 2'b00, ana(v, fs)}, 0);
		// settings land right after an update, so the next one takes exactly one filter step
		wupd();
		apb(1, IDX_SMOOTH, 32'h4, 32'h0, 0);
		apb(1, IDX_RESON, 32'h2, 32'h0, 0);
		mv_req <= -16'sd8000;
		spd_req <= 16'sd1000;
		x = ana(-8000, fs);
		y = ana(v, fs);
		y = y + (x - y) / 4;
		y = y + (x - y) / 4;
		r = s + (1000 - s) / 2;
		r = r + (1000 - r) / 2;
		expc(16'(y), 1'b0, 16'(r));
		tally_and_finish();
	end
endmodule

// ---- test/trq_far_side.sv ----
// model of the external controller contacts, analog source and speed loop feed
`timescale 1ns/1ps
module trq_far_side (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// requests from the bench
	input wire logic [1:0] sel_req,
	input wire logic signed [15:0] mv_req,
	input wire logic signed [15:0] spd_req,
	// pins toward the block
	output logic torque_select_bit0,
	output logic torque_select_bit1,
	output logic signed [15:0] analog_in_mv,
	output logic signed [15:0] speed_loop_in
);
	// contact closed drives 1, open drives 0; registered so changes leave the edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			torque_select_bit0 <= 1'b0;
			torque_select_bit1 <= 1'b0;
			analog_in_mv <= 16'sh0000;
			speed_loop_in <= 16'sh0000;
		end else begin
			torque_select_bit0 <= sel_req[0];
			torque_select_bit1 <= sel_req[1];
			analog_in_mv <= mv_req; // source spans +/-10 V
			speed_loop_in <= spd_req;
		end
	end
endmodule
